// File: core/rca_core.sv
`timescale 1ns/100ps
module rca_core
	import rca_pkg::*;
#(
	parameter int GPR_SIZE = GPR_BYTES
)(
	// clock, reset, enable
	input  wire logic               clk_sys,
	input  wire logic               reset,
	input  wire logic               ce,
	// program memory bus
	output rca_pc_t                 prog_addr,
	input  wire logic [INSTR_W-1:0] prog_data,
	// oscillator mode strap and clock out
	input  wire logic               resistor_capacitor_oscillator_mode,
	output logic                    quarter_rate_clock_output,
	// visible core state
	output logic [7:0]              acc_value,
	output rca_flags_t              status_flags,
	output logic                    pipe_valid
);
	// ---------------------------------------------------------------
	// parameter check
	// ---------------------------------------------------------------
	if (GPR_SIZE < 1 || GPR_SIZE > 256 - int'(GPR_BASE) || PHASES != 4)
		$error("rca_core: unsupported data memory size or phase count");

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [1:0]   phase;
	rca_pc_t      pc;
	rca_instr_t   ir;
	logic         ir_valid;
	logic [7:0]   acc;
	rca_flags_t   flags;
	logic [7:0]   fsr;
	logic [3:0]   pclath;
	logic [7:0]   ram [GPR_SIZE];

	logic [1:0]   next_phase;
	rca_pc_t      next_pc;
	rca_instr_t   next_ir;
	logic         next_ir_valid;
	logic [7:0]   next_acc;
	rca_flags_t   next_flags;
	logic [7:0]   next_fsr;
	logic [3:0]   next_pclath;

	logic         cyc_end, exec, is_goto, is_lit, is_sub, branch;
	logic         wr_file, wr_acc, in_gpr, ram_we;
	logic [7:0]   faddr, fdata, opnd, alu_res, ram_idx;
	rca_flags_t   alu_flags, alu_upd;

	assign prog_addr    = pc;
	assign acc_value    = acc;
	assign status_flags = flags;
	assign pipe_valid   = ir_valid;

	// ---------------------------------------------------------------
	// decode and operand selection
	// ---------------------------------------------------------------
	always_comb begin
		cyc_end = ce && (phase == PH_LAST);
		exec    = cyc_end && ir_valid;
		is_goto = (ir.op[3:2] == 2'b11);
		is_lit  = (ir.op == OP_ADDLW) || (ir.op == OP_SUBTRACT_ACC_FROM_LITERAL);
		is_sub  = (ir.op == OP_SUBTRACT_ACC_FROM_FILE) || (ir.op == OP_SUBTRACT_ACC_FROM_LITERAL);
		// indirect access goes through the pointer
		faddr   = (ir.lit == ADDR_INDF) ? fsr : ir.lit;
		in_gpr  = (faddr >= GPR_BASE) &&
		          ({1'b0, faddr} < 9'(int'(GPR_BASE) + GPR_SIZE));
		ram_idx = faddr - GPR_BASE;
		// special registers in data space, pc included
		unique case (faddr)
			ADDR_PCL:    fdata = pc[7:0];
			ADDR_STATUS: fdata = {5'h00, flags.z, flags.dc, flags.c};
			ADDR_FSR:    fdata = fsr;
			ADDR_PCLATH: fdata = {4'h0, pclath};
			default:     fdata = in_gpr ? ram[ram_idx] : 8'h00;
		endcase
		// literal or file second operand; acc for single ops with src_acc set
		if (is_lit)
			opnd = ir.lit;
		else if (ir.src_acc && (ir.op == OP_RLF || ir.op == OP_RRF ||
		                        ir.op == OP_COMF || ir.op == OP_MOVF))
			opnd = acc;
		else
			opnd = fdata;
		// the accumulator is only a destination, never an address
		wr_file = exec && !is_goto && !is_lit &&
		          (ir.to_file || ir.op == OP_MOVWF);
		wr_acc  = exec && !is_goto && !wr_file;
		ram_we  = wr_file && in_gpr;
		// goto, or any write landing on the low pc byte
		branch  = exec && (is_goto || (wr_file && faddr == ADDR_PCL));
	end

	rca_alu u_alu (
		.op    (ir.op),
		.acc   (acc),
		.opnd  (opnd),
		.c_in  (flags.c),
		.res   (alu_res),
		.flags (alu_flags),
		.upd   (alu_upd)
	);

	// ---------------------------------------------------------------
	// next state: phase, fetch pipeline and architectural registers
	// ---------------------------------------------------------------
	always_comb begin
		next_phase    = phase + 2'h1; // four clocks per cycle
		next_pc       = pc;
		next_ir       = ir;
		next_ir_valid = ir_valid;
		next_acc      = acc;
		next_flags    = flags;
		next_fsr      = fsr;
		next_pclath   = pclath;
		if (cyc_end) begin
			// fetch overlaps execute: one full word per cycle
			next_ir       = rca_instr_t'(prog_data);
			next_ir_valid = 1'b1;
			next_pc       = rca_pc_t'(pc + 12'h001);
		end
		if (wr_acc)
			next_acc = alu_res;
		if (wr_file) begin
			unique case (faddr)
				ADDR_STATUS: next_flags = '{z:  alu_res[ST_Z],
				                            dc: alu_res[ST_DC],
				                            c:  alu_res[ST_C]};
				ADDR_FSR:    next_fsr    = alu_res;
				ADDR_PCLATH: next_pclath = alu_res[3:0];
				ADDR_PCL:    next_pc     = {pclath, alu_res};
				default:     next_pc     = next_pc;
			endcase
		end
		if (exec) begin
			// flags the operation owns win over a status store
			if (alu_upd.c)  next_flags.c  = alu_flags.c;
			if (alu_upd.dc) next_flags.dc = alu_flags.dc;
			if (alu_upd.z)  next_flags.z  = alu_flags.z;
		end
		if (exec && is_goto)
			next_pc = rca_pc_t'({ir.op[1:0], ir.to_file, ir.src_acc, ir.lit});
		if (branch)
			next_ir_valid = 1'b0; // fetched word is dropped
	end

	// ---------------------------------------------------------------
	// registers; everything holds while ce is low
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			phase    <= 2'h0;
			pc       <= RST_PC;
			ir       <= '0;
			ir_valid <= 1'b0;
			acc      <= RST_DATA;
			flags    <= '0;
			fsr      <= RST_DATA;
			pclath   <= RST_HI;
		end else if (ce) begin
			phase    <= next_phase;
			pc       <= next_pc;
			ir       <= next_ir;
			ir_valid <= next_ir_valid;
			acc      <= next_acc;
			flags    <= next_flags;
			fsr      <= next_fsr;
			pclath   <= next_pclath;
		end
	end

	// general purpose storage, 176 bytes by default; no reset
	always_ff @(posedge clk_sys) begin
		if (ram_we)
			ram[ram_idx] <= alu_res;
	end

	// ---------------------------------------------------------------
	// quarter-rate clock output and mode strap
	// ---------------------------------------------------------------
	rca_clkout u_clkout (
		.clk_sys     (clk_sys),
		.reset       (reset),
		.ce          (ce),
		.rc_mode_pin (resistor_capacitor_oscillator_mode),
		.phase       (phase),
		.clk_quarter (quarter_rate_clock_output)
	);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_four_ticks;
		ce [*4];
	endsequence

	a_cycle_four: assert property (
		cyc_end ##1 s_four_ticks |-> cyc_end)
		else $error("instruction cycle is not four clocks");
	a_seq_fetch: assert property (
		(cyc_end && !branch) |=> pc == rca_pc_t'($past(pc) + 12'h001))
		else $error("sequential fetch did not advance pc");
	a_branch_flush: assert property (
		branch |=> !ir_valid [*4])
		else $error("branch did not flush the fetched word");
	a_acc_write: assert property (
		wr_acc |=> acc == $past(alu_res))
		else $error("accumulator not loaded with result");
	a_sub_carry: assert property (
		(exec && is_sub && !wr_file) |=> flags.c == ($past(opnd) >= $past(acc)))
		else $error("subtract carry polarity wrong");
	a_sub_nibble: assert property (
		(exec && is_sub && !wr_file) |=>
		flags.dc == ($past(opnd[3:0]) >= $past(acc[3:0])))
		else $error("subtract nibble borrow wrong");
	a_add_zero: assert property (
		(exec && ir.op == OP_ADDWF && !wr_file) |=>
		flags.z == ($past(alu_res) == 8'h00))
		else $error("zero flag wrong after add");
	a_fsr_store: assert property (
		(wr_file && faddr == ADDR_FSR) |=> fsr == $past(alu_res))
		else $error("pointer register not written");
	a_indirect_st: assert property (
		(ram_we && ir.lit == ADDR_INDF) |=> ram[$past(ram_idx)] == $past(alu_res))
		else $error("indirect store missed");

	// ---------------------------------------------------------------
	// datapath checks against plain eight-bit arithmetic, then operand routing, fetch and enable checks
	// ---------------------------------------------------------------
	// results and flags of ops writing the accumulator, computed independently of the alu
	a_add_carry: assert property (
		(exec && (ir.op == OP_ADDWF || ir.op == OP_ADDLW) && !wr_file) |=>
		flags.c == ((9'($past(opnd)) + 9'($past(acc))) > 9'h0FF))
		else $error("add carry wrong");
	a_add_nibble: assert property (
		(exec && (ir.op == OP_ADDWF || ir.op == OP_ADDLW) && !wr_file) |=>
		flags.dc == ((5'($past(opnd[3:0])) + 5'($past(acc[3:0]))) > 5'h0F))
		else $error("add nibble carry wrong");
	a_sub_result: assert property (
		(exec && is_sub && wr_acc) |=> acc == 8'($past(opnd) - $past(acc)))
		else $error("subtract result wrong");
	a_and_result: assert property (
		(exec && ir.op == OP_ANDWF && wr_acc) |=>
		acc == ($past(opnd) & $past(acc)))
		else $error("logical and result wrong");
	a_rlf_carry: assert property (
		(exec && ir.op == OP_RLF && !wr_file) |=> flags.c == $past(opnd[7]))
		else $error("rotate left carry wrong");

	// operand routing: literal, or the accumulator for OP_COMF with src_acc set
	a_lit_operand: assert property (
		(exec && is_lit) |-> opnd == ir.lit)
		else $error("literal operand not selected");
	a_single_acc: assert property (
		(exec && ir.src_acc && ir.op == OP_COMF) |-> opnd == acc)
		else $error("accumulator operand not selected");

	// fetch pipeline: the whole word lands, and a goto goes to its target
	a_fetch_word: assert property (
		cyc_end |=> ir == rca_instr_t'($past(prog_data)))
		else $error("fetched word not latched");
	a_pipe_refill: assert property (
		(cyc_end && !branch) |=> ir_valid)
		else $error("sequential fetch left pipe empty");
	a_goto_target: assert property (
		(exec && is_goto) |=> pc == $past(ir[11:0]))
		else $error("goto did not reach its target");

	// a low enable must freeze the cycle phase as well
	a_phase_hold: assert property (
		!ce |=> phase == $past(phase))
		else $error("phase moved while enable low");
endmodule

// File: core/rca_pkg.sv
// Contract
// - Instruction fetch and data access use separate memories on separate buses.
// - Every instruction word is fourteen bits, one program word each.
// - Program bus is fourteen bits and delivers one word per cycle.
// - Next instruction is fetched while the current one executes.
// - Non-branch instructions take one cycle: 500 ns at 8 MHz.
// - Program space is 4K x 14; general data storage is 176 x 8.
// - Special registers, program counter included, sit in data space.
// - Files reachable by direct address and indirectly through a pointer.
// - ALU is eight bits: add, subtract, shift and logical operations.
// - Arithmetic is two's complement.
// - Two-operand ops use accumulator plus file register or literal.
// - Single-operand ops use accumulator or a file register.
// - Accumulator is eight bits and has no data-space address.
// - ALU updates carry, nibble carry and zero flags per instruction.
// - In subtraction carry and nibble carry report borrows.
// - In RC oscillator mode, drive a clock at quarter input rate.
package rca_pkg;
	// ---------------------------------------------------------------
	// widths and sizes
	// ---------------------------------------------------------------
	localparam int INSTR_W    = 14;
	localparam int DATA_W     = 8;
	localparam int PC_W       = 12;
	localparam int PROG_WORDS = 4096;
	localparam int GPR_BYTES  = 176;
	// ---------------------------------------------------------------
	// timing: oscillator clocks per instruction cycle
	// ---------------------------------------------------------------
	localparam int OSC_MHZ        = 8;
	localparam int INSTR_CYCLE_NS = 500;
	localparam int PHASES = (INSTR_CYCLE_NS * OSC_MHZ) / 1000;
	localparam logic [1:0] PH_LAST = 2'(PHASES - 1);
	localparam logic [1:0] PH_HIGH = 2'h1; // quarter clock rises after this
	// ---------------------------------------------------------------
	// data space map
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_INDF   = 8'h00;
	localparam logic [7:0] ADDR_PCL    = 8'h02;
	localparam logic [7:0] ADDR_STATUS = 8'h03;
	localparam logic [7:0] ADDR_FSR    = 8'h04;
	localparam logic [7:0] ADDR_PCLATH = 8'h0A;
	localparam logic [7:0] GPR_BASE    = 8'h20;
	// status field positions and reset values
	localparam int ST_C  = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z  = 2;
	localparam logic [7:0]  RST_DATA = 8'h00;
	localparam logic [11:0] RST_PC   = 12'h000;
	localparam logic [3:0]  RST_HI   = 4'h0;
	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef logic [PC_W-1:0] rca_pc_t;
	typedef enum logic [3:0] {
		OP_ADDWF = 4'h0, OP_SUBTRACT_ACC_FROM_FILE = 4'h1, OP_ANDWF = 4'h2, OP_IORWF = 4'h3,
		OP_XORWF = 4'h4, OP_RLF   = 4'h5, OP_RRF   = 4'h6, OP_COMF  = 4'h7,
		OP_MOVF  = 4'h8, OP_MOVWF = 4'h9, OP_ADDLW = 4'hA, OP_SUBTRACT_ACC_FROM_LITERAL = 4'hB,
		OP_GOTO0 = 4'hC, OP_GOTO1 = 4'hD, OP_GOTO2 = 4'hE, OP_GOTO3 = 4'hF
	} rca_op_t;
	typedef struct packed {
		logic z;
		logic dc;
		logic c;
	} rca_flags_t;
	// instruction fields: op, result-to-file, operand-is-acc, literal
	typedef struct packed {
		rca_op_t    op;
		logic       to_file;
		logic       src_acc;
		logic [7:0] lit;
	} rca_instr_t;
endpackage

// File: core/rca_alu.sv
`timescale 1ns/100ps
module rca_alu
	import rca_pkg::*;
(
	// operands
	input  wire rca_op_t    op,
	input  wire logic [7:0] acc,
	input  wire logic [7:0] opnd,
	input  wire logic       c_in,
	// results
	output logic [7:0]      res,
	output rca_flags_t      flags,
	output rca_flags_t      upd
);
	logic [8:0] sum;
	logic [4:0] nib;

	// ---------------------------------------------------------------
	// eight-bit operations, two's complement arithmetic
	// ---------------------------------------------------------------
	always_comb begin
		sum   = 9'h000;
		nib   = 5'h00;
		res   = opnd;
		flags = '{z: 1'b0, dc: 1'b0, c: 1'b0};
		upd   = '{z: 1'b0, dc: 1'b0, c: 1'b0};
		unique case (op)
			OP_ADDWF, OP_ADDLW: begin
				sum = {1'b0, opnd} + {1'b0, acc};
				nib = {1'b0, opnd[3:0]} + {1'b0, acc[3:0]};
				res = sum[7:0];
				upd = '{z: 1'b1, dc: 1'b1, c: 1'b1};
			end
			OP_SUBTRACT_ACC_FROM_FILE, OP_SUBTRACT_ACC_FROM_LITERAL: begin
				// add the complement: carry out means no borrow
				sum = {1'b0, opnd} + {1'b0, ~acc} + 9'h001;
				nib = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
				res = sum[7:0];
				upd = '{z: 1'b1, dc: 1'b1, c: 1'b1};
			end
			OP_ANDWF: begin res = opnd & acc; upd.z = 1'b1; end
			OP_IORWF: begin res = opnd | acc; upd.z = 1'b1; end
			OP_XORWF: begin res = opnd ^ acc; upd.z = 1'b1; end
			OP_RLF: begin // shift through carry
				res = {opnd[6:0], c_in};
				sum[8] = opnd[7];
				upd.c  = 1'b1;
			end
			OP_RRF: begin
				res = {c_in, opnd[7:1]};
				sum[8] = opnd[0];
				upd.c  = 1'b1;
			end
			OP_COMF: begin res = ~opnd; upd.z = 1'b1; end
			OP_MOVF: begin res = opnd; upd.z = 1'b1; end
			OP_MOVWF: res = acc;
			OP_GOTO0, OP_GOTO1, OP_GOTO2, OP_GOTO3: res = opnd;
		endcase
		flags.c  = sum[8];
		flags.dc = nib[4];
		flags.z  = (res == 8'h00);
	end
endmodule

// File: core/rca_clkout.sv
`timescale 1ns/100ps
module rca_clkout
	import rca_pkg::*;
(
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic       ce,
	// mode strap pin and cycle phase
	input  wire logic       rc_mode_pin,
	input  wire logic [1:0] phase,
	// quarter-rate clock
	output logic            clk_quarter
);
	logic sync1, sync2, sync3, rc_mode;
	logic next_rc_mode, next_clk_quarter;

	// ---------------------------------------------------------------
	// strap capture: a change counts once stages two and three agree
	// ---------------------------------------------------------------
	always_comb begin
		next_rc_mode     = (sync2 == sync3) ? sync3 : rc_mode;
		next_clk_quarter = clk_quarter;
		if (!rc_mode)
			next_clk_quarter = 1'b0; // crystal modes: pin is not ours
		else if (phase == PH_HIGH)
			next_clk_quarter = 1'b1;
		else if (phase == PH_LAST)
			next_clk_quarter = 1'b0;
	end

	// ---------------------------------------------------------------
	// registers; stage one feeds only stage two
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sync1       <= 1'b0;
			sync2       <= 1'b0;
			sync3       <= 1'b0;
			rc_mode     <= 1'b0;
			clk_quarter <= 1'b0;
		end else if (ce) begin
			sync1       <= rc_mode_pin;
			sync2       <= sync1;
			sync3       <= sync2;
			rc_mode     <= next_rc_mode;
			clk_quarter <= next_clk_quarter;
		end
	end

	a_clkout_rise: assert property (@(posedge clk_sys) disable iff (reset)
		(ce && rc_mode && phase == PH_HIGH) |=> clk_quarter)
		else $error("quarter clock did not rise");
	a_clkout_fall: assert property (@(posedge clk_sys) disable iff (reset)
		(ce && phase == PH_LAST) |=> !clk_quarter)
		else $error("quarter clock did not fall");
endmodule

// File: dv/tb_top.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin \
	checks++; \
	if ((got) !== (exp)) begin \
		mismatches++; \
		$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
	end \
end
module tb_top
	import rca_pkg::*;
;
	// ---------------------------------------------------------------
	// stimulus and observed signals
	// ---------------------------------------------------------------
	logic               clk_sys   = 1'b0;
	logic               reset     = 1'b1;
	logic               ce        = 1'b1;
	logic               rc_mode   = 1'b0;
	logic [INSTR_W-1:0] prog_data = '0;
	rca_pc_t            prog_addr;
	logic               clk_q;
	logic [7:0]         acc_value;
	rca_flags_t         status_flags;
	logic               pipe_valid;
	int                 mismatches = 0;
	int                 checks     = 0;
	int                 cyc        = 0;
	int                 last_cyc   = 0;
	logic [13:0]        rom [0:PROG_WORDS-1];

	// free-running clock and an edge counter for timing checks
	always #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;
	// program memory answers from the registered address
	always @(posedge clk_sys) prog_data <= rom[prog_addr];

	rca_core #(.GPR_SIZE(GPR_BYTES)) dut (
		.clk_sys                            (clk_sys),
		.reset                              (reset),
		.ce                                 (ce),
		.prog_addr                          (prog_addr),
		.prog_data                          (prog_data),
		.resistor_capacitor_oscillator_mode (rc_mode),
		.quarter_rate_clock_output          (clk_q),
		.acc_value                          (acc_value),
		.status_flags                       (status_flags),
		.pipe_valid                         (pipe_valid)
	);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [13:0] ins(input logic [3:0] op,
		input logic f, input logic s, input logic [7:0] l);
		return {op, f, s, l};
	endfunction

	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// bounded wait; sampling on the falling edge keeps races away
	task automatic wait_addr(input rca_pc_t a);
		int n = 0;
		while (prog_addr !== a && n < 40) begin
			@(negedge clk_sys);
			n++;
		end
		`CHK(prog_addr, a)
	endtask

	// the word two below the awaited address has just executed
	task automatic step(input rca_pc_t w, input logic [7:0] a,
		input logic [2:0] f, input int gap, input logic pv);
		wait_addr(w);
		`CHK(acc_value, a)
		`CHK(status_flags, f)
		`CHK(pipe_valid, pv)
		if (gap > 0) `CHK(cyc - last_cyc, gap)
		last_cyc = cyc;
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic do_reset();
		@(posedge clk_sys);
		reset <= 1'b1;
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		`CHK(prog_addr, 12'h000)
		`CHK(acc_value, 8'h00)
		`CHK(status_flags, 3'h0)
		`CHK(pipe_valid, 1'b0)
		`CHK(clk_q, 1'b0)
		@(posedge clk_sys);
		reset <= 1'b0;
	endtask

	// arithmetic, flags, direct and indirect data, branch flush
	task automatic run_program();
		step(12'h002, 8'h05, 3'h0, 0, 1'b1);
		step(12'h003, 8'h00, 3'h7, 4, 1'b1);
		step(12'h004, 8'h03, 3'h3, 4, 1'b1);
		step(12'h005, 8'hFF, 3'h0, 4, 1'b1);
		step(12'h006, 8'h00, 3'h7, 4, 1'b1);
		step(12'h007, 8'h3C, 3'h0, 4, 1'b1);
		step(12'h008, 8'h3C, 3'h0, 4, 1'b1);
		step(12'h009, 8'h00, 3'h7, 4, 1'b1);
		step(12'h00A, 8'h3C, 3'h0, 4, 1'b1);
		step(12'h00B, 8'h00, 3'h4, 4, 1'b1);
		step(12'h00C, 8'h3C, 3'h0, 4, 1'b1);
		step(12'h00D, 8'hC3, 3'h0, 4, 1'b1);
		step(12'h00E, 8'h00, 3'h4, 4, 1'b1);
		step(12'h00F, 8'h78, 3'h4, 4, 1'b1);
		step(12'h010, 8'hC4, 3'h2, 4, 1'b1);
		step(12'h011, 8'h88, 3'h3, 4, 1'b1);
		step(12'h012, 8'hC4, 3'h2, 4, 1'b1);
		step(12'h013, 8'h3C, 3'h2, 4, 1'b1);
		step(12'h014, 8'h20, 3'h3, 4, 1'b1);
		step(12'h015, 8'h20, 3'h3, 4, 1'b1);
		step(12'h016, 8'h3C, 3'h3, 4, 1'b1);
		step(12'h017, 8'h16, 3'h3, 4, 1'b1);
		step(12'h030, 8'h16, 3'h3, 4, 1'b0);
		step(12'h032, 8'h27, 3'h0, 8, 1'b1);
		step(12'h033, 8'h27, 3'h0, 4, 1'b1);
	endtask

	// quarter clock follows the cycle phase only in rc mode
	task automatic quarter_clock();
		logic [3:0] seen;
		logic       hi = 1'b0;
		rca_pc_t    a0;
		@(posedge clk_sys);
		rc_mode <= 1'b1;
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
		a0 = prog_addr;
		wait_addr(a0 ^ 12'h001);
		for (int i = 0; i < 4; i++) begin
			seen[i] = clk_q;
			@(negedge clk_sys);
		end
		`CHK(seen, 4'hC)
		@(posedge clk_sys);
		rc_mode <= 1'b0;
		repeat (8) @(posedge clk_sys);
		repeat (8) begin
			@(negedge clk_sys);
			hi = hi | clk_q;
		end
		`CHK(hi, 1'b0)
	endtask

	// a held enable freezes the core in place
	task automatic hold_enable();
		rca_pc_t a0;
		@(posedge clk_sys);
		ce <= 1'b0;
		@(negedge clk_sys);
		a0 = prog_addr;
		repeat (12) @(negedge clk_sys);
		`CHK(prog_addr, a0)
		`CHK(acc_value, 8'h27)
		@(posedge clk_sys);
		ce <= 1'b1;
	endtask

	// ---------------------------------------------------------------
	// main sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		for (int i = 0; i < PROG_WORDS; i++) rom[i] = '0;
		rom[0]  = ins(OP_ADDLW, 1'b0, 1'b0, 8'h05);
		rom[1]  = ins(OP_SUBTRACT_ACC_FROM_LITERAL, 1'b0, 1'b0, 8'h05);
		rom[2]  = ins(OP_SUBTRACT_ACC_FROM_LITERAL, 1'b0, 1'b0, 8'h03);
		rom[3]  = ins(OP_SUBTRACT_ACC_FROM_LITERAL, 1'b0, 1'b0, 8'h02);
		rom[4]  = ins(OP_ADDLW, 1'b0, 1'b0, 8'h01);
		rom[5]  = ins(OP_ADDLW, 1'b0, 1'b0, 8'h3C);
		rom[6]  = ins(OP_MOVWF, 1'b1, 1'b0, GPR_BASE);
		rom[7]  = ins(OP_ADDLW, 1'b0, 1'b0, 8'hC4);
		rom[8]  = ins(OP_ADDWF, 1'b0, 1'b0, GPR_BASE);
		rom[9]  = ins(OP_XORWF, 1'b0, 1'b0, GPR_BASE);
		rom[10] = ins(OP_IORWF, 1'b0, 1'b0, GPR_BASE);
		rom[11] = ins(OP_COMF,  1'b0, 1'b1, 8'h00);
		rom[12] = ins(OP_ANDWF, 1'b0, 1'b0, GPR_BASE);
		rom[13] = ins(OP_RLF,   1'b0, 1'b0, GPR_BASE);
		rom[14] = ins(OP_SUBTRACT_ACC_FROM_FILE, 1'b0, 1'b0, GPR_BASE);
		rom[15] = ins(OP_RLF,   1'b0, 1'b1, 8'h00);
		rom[16] = ins(OP_RRF,   1'b0, 1'b1, 8'h00);
		rom[17] = ins(OP_MOVF,  1'b0, 1'b0, GPR_BASE);
		rom[18] = ins(OP_SUBTRACT_ACC_FROM_LITERAL, 1'b0, 1'b0, 8'h5C);
		rom[19] = ins(OP_MOVWF, 1'b1, 1'b0, ADDR_FSR);
		rom[20] = ins(OP_MOVF,  1'b0, 1'b0, ADDR_INDF);
		rom[21] = ins(OP_MOVF,  1'b0, 1'b0, ADDR_PCL);
		rom[22] = {2'b11, 12'h030};
		rom[23] = ins(OP_ADDLW, 1'b0, 1'b0, 8'h01); // must be flushed
		rom[48] = ins(OP_ADDLW, 1'b0, 1'b0, 8'h11);
		rom[49] = ins(OP_MOVWF, 1'b1, 1'b0, ADDR_INDF); // store via pointer
		rom[50] = {2'b11, 12'h032};
		do_reset();
		run_program();
		quarter_clock();
		hold_enable();
		do_reset();
		wrap_up();
	end

	// the whole run needs well under a thousand cycles
	initial begin
		#50000;
		mismatches++;
		wrap_up();
	end
endmodule
